// ==== dist_eval.sv ====
// Purpose: distance evaluation, analog output code, pots, teach and peer timing
// Assumes: one distance sample per measuring cycle, pots as 8-bit positions
// Notes: registers over classic wishbone; sync_teach_line is open-drain
// Functional notes
// R1 - current modes drive code over 0..20 mA or 4..20 mA by distance
// R2 - voltage mode drives 0..10 V, only on voltage variants
// R3 - inactive output holds code at zero
// R4 - rising or falling characteristic selectable
// R5 - host keeps analog start below end and inside sensing range
// R6 - no object, near and far each pick max or min value
// R7 - minimum is 0 mA, 4 mA or 0 V per variant
// R8 - maximum is 20 mA or 10 V
// R9 - close range is fixed, read only, writes rejected
// R10 - only echoes between close range end and sensing end count
// R11 - sensing end limited to close end..10100 mm, service access only
// R12 - object in enabled blind zone behaves as no object
// R13 - two blind zones, each with start, end and disable
// R14 - each pot assignable to one range limit or off
// R15 - pot stops map to adjustment range start and end
// R16 - line grounded three seconds with object teaches its distance
// R17 - green indicator half a second, teach repeats every three seconds
// R18 - no object during teach leaves limits unchanged
// R19 - teach disabled after reset
// R20 - sync mode uses longest cycle, holds output in extension
// R21 - multiplex transmits in address order over shared count
// R22 - teach configuration disables sync and multiplex
// R23 - analog code interpolates linearly, updated once per cycle
`timescale 1ns/100ps
module dist_eval #(
  parameter int HOLD_CYCLES = dist_eval_pkg::HOLD_CYC,
  parameter int LED_CYCLES = dist_eval_pkg::LED_CYC,
  parameter logic VOLT_VARIANT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic meas_valid_i,
  input wire logic echo_found_i,
  input wire logic [15:0] echo_dist_i,
  input wire logic [7:0] pot1_pos_i,
  input wire logic [7:0] pot2_pos_i,
  input wire logic sync_teach_line_i,
  output logic sync_teach_line_o,
  output logic sync_teach_line_oe_o,
  input wire logic peer_cycle_end_i,
  output logic tx_start_o,
  output logic out_hold_o,
  output logic [15:0] analog_code_o,
  output logic led_green_o
);
  import dist_eval_pkg::*;

  typedef struct packed {
    logic [31:0] rdat;
    logic ack;
    logic [1:0] amode;
    logic rising;
    logic [2:0] beh;
    logic teach_en;
    logic [15:0] a_start;
    logic [15:0] a_end;
    logic [15:0] sense_end;
    logic [15:0] bz1_s;
    logic [15:0] bz1_e;
    logic bz1_off;
    logic [15:0] bz2_s;
    logic [15:0] bz2_e;
    logic bz2_off;
    logic [2:0] pot1_sel;
    logic [2:0] pot2_sel;
    logic [15:0] adj_s;
    logic [15:0] adj_e;
    logic [1:0] lmode_cfg;
    logic [3:0] addr;
    logic [3:0] count;
    logic [3:0][15:0] sp;
    logic svc;
    logic rej;
    logic [2:0] ln;
    lmode_t lmode;
    logic [31:0] hold_cnt;
    logic [31:0] led_cnt;
    logic teach_seen;
    logic [15:0] teach_dist;
    logic [3:0] slot;
    logic own_done;
    logic tx;
    logic hold;
    logic drive;
    logic [15:0] code;
    logic led;
  } st_t;

  st_t r, nxt;
  logic line_low;
  logic valid_obj;
  logic [31:0] span, off, scaled;
  logic [15:0] vmin, vmax, pos;
  lim_t tsel;

  function automatic logic [15:0] pot_map(input logic [7:0] p, input logic [15:0] s,
                                          input logic [15:0] e);
    logic [31:0] t;
    t = 32'(p) * 32'(e - s) / 32'h0000_00FF;
    return s + t[15:0];
  endfunction

  always_comb begin
    nxt = r;
    nxt.ack = 1'b0;
    nxt.tx = 1'b0;
    nxt.ln = {r.ln[1:0], sync_teach_line_i};
    line_low = (r.ln[2] == 1'b0) && (r.ln[1] == 1'b0);
    valid_obj = echo_found_i && (echo_dist_i >= CLOSE_RANGE_MM) && (echo_dist_i <= r.sense_end) // R10
      && !(!r.bz1_off && echo_dist_i >= r.bz1_s && echo_dist_i <= r.bz1_e) // R12 R13
      && !(!r.bz2_off && echo_dist_i >= r.bz2_s && echo_dist_i <= r.bz2_e); // R13
    // bus slave
    if (cyc_i && stb_i && !r.ack) begin
      nxt.ack = 1'b1;
      nxt.rdat = 32'h0000_0000;
      unique case (adr_i)
        A_CTRL: nxt.rdat = {24'h0, r.teach_en, r.beh, r.rising, 1'b0, r.amode};
        A_ARANGE: nxt.rdat = {r.a_end, r.a_start};
        A_SENSE: nxt.rdat = {16'h0, r.sense_end};
        A_BZ1: nxt.rdat = {r.bz1_off, r.bz1_e[14:0], r.bz1_s};
        A_BZ2: nxt.rdat = {r.bz2_off, r.bz2_e[14:0], r.bz2_s};
        A_POT: nxt.rdat = {26'h0, r.pot2_sel, r.pot1_sel};
        A_ADJ: nxt.rdat = {r.adj_e, r.adj_s};
        A_SYNC: nxt.rdat = {20'h0, r.count, r.addr, 2'h0, r.lmode_cfg};
        A_STAT: nxt.rdat = {26'h0, r.rej, r.led, r.lmode};
        A_CLOSE: nxt.rdat = {16'h0, CLOSE_RANGE_MM}; // R9
        A_SP: nxt.rdat = {16'h0, r.sp[0]};
        default: nxt.rdat = 32'h0000_0000;
      endcase
      if (we_i && sel_i == 4'hF) begin
        unique case (adr_i)
          A_CTRL: begin
            if (!VOLT_VARIANT || dat_i[1:0] == AM_OFF || dat_i[1:0] == AM_V010) // R1 R2
              nxt.amode = dat_i[1:0];
            if (VOLT_VARIANT && (dat_i[1:0] == AM_I020 || dat_i[1:0] == AM_I420))
              nxt.amode = r.amode;
            if (!VOLT_VARIANT && dat_i[1:0] == AM_V010)
              nxt.amode = r.amode;
            nxt.rising = dat_i[3]; // R4
            nxt.beh = dat_i[6:4]; // R6
            nxt.teach_en = dat_i[7];
          end
          A_ARANGE: begin
            nxt.a_start = dat_i[15:0];
            nxt.a_end = dat_i[31:16];
          end
          A_SENSE: begin
            if (r.svc && dat_i[15:0] >= CLOSE_RANGE_MM && dat_i[15:0] <= SENSE_CEIL_MM) // R11
              nxt.sense_end = dat_i[15:0];
            else
              nxt.rej = 1'b1;
          end
          A_BZ1: begin
            nxt.bz1_s = dat_i[15:0];
            nxt.bz1_e = {1'b0, dat_i[30:16]};
            nxt.bz1_off = dat_i[31];
          end
          A_BZ2: begin
            nxt.bz2_s = dat_i[15:0];
            nxt.bz2_e = {1'b0, dat_i[30:16]};
            nxt.bz2_off = dat_i[31];
          end
          A_POT: begin
            nxt.pot1_sel = dat_i[2:0]; // R14
            nxt.pot2_sel = dat_i[5:3]; // R14
          end
          A_ADJ: begin
            nxt.adj_s = dat_i[15:0];
            nxt.adj_e = dat_i[31:16];
          end
          A_SYNC: begin
            nxt.lmode_cfg = dat_i[1:0];
            nxt.addr = dat_i[7:4];
            nxt.count = dat_i[11:8];
          end
          A_CLOSE: nxt.rej = 1'b1; // R9
          A_SVC: nxt.svc = (dat_i == SVC_KEY);
          A_STAT: nxt.rej = 1'b0;
          A_SP: nxt.sp[0] = dat_i[15:0];
          default: ;
        endcase
      end
    end
    // pots override their limits
    for (int k = 0; k < 2; k++) begin
      tsel = lim_t'(k == 0 ? r.pot1_sel : r.pot2_sel);
      pos = pot_map(k == 0 ? pot1_pos_i : pot2_pos_i, r.adj_s, r.adj_e); // R15
      unique case (tsel)
        LIM_SP11, LIM_SP12, LIM_SP21, LIM_SP22: nxt.sp[2'(tsel - LIM_SP11)] = pos; // R14
        LIM_ASTART: nxt.a_start = pos; // R14
        LIM_AEND: nxt.a_end = pos;
        default: ;
      endcase
    end
    // link mode
    if (r.teach_en)
      nxt.lmode = LS_TEACH; // R22
    else if (r.lmode_cfg == 2'h1)
      nxt.lmode = LS_SYNC;
    else if (r.lmode_cfg == 2'h2)
      nxt.lmode = LS_MUX;
    else
      nxt.lmode = LS_IDLE;
    nxt.drive = 1'b0;
    // countdown first so that a new teach indication wins over it
    if (r.led_cnt != 32'h0)
      nxt.led_cnt = r.led_cnt - 32'h1;
    unique case (r.lmode)
      LS_TEACH: begin
        if (line_low) begin // R16
          if (meas_valid_i && valid_obj) begin
            nxt.teach_seen = 1'b1;
            nxt.teach_dist = echo_dist_i;
          end else if (meas_valid_i) begin
            nxt.teach_seen = 1'b0;
          end
          if (r.hold_cnt >= 32'(HOLD_CYCLES - 1)) begin
            nxt.hold_cnt = 32'h0; // R17
            if (r.teach_seen) begin // R18
              tsel = lim_t'(r.pot1_sel);
              unique case (tsel)
                LIM_SP11, LIM_SP12, LIM_SP21, LIM_SP22: nxt.sp[2'(tsel - LIM_SP11)] = r.teach_dist;
                LIM_ASTART: nxt.a_start = r.teach_dist;
                LIM_AEND: nxt.a_end = r.teach_dist;
                default: ;
              endcase
              nxt.led_cnt = 32'(LED_CYCLES); // R17
            end
          end else begin
            nxt.hold_cnt = r.hold_cnt + 32'h1;
          end
        end else begin
          nxt.hold_cnt = 32'h0;
          nxt.teach_seen = 1'b0;
        end
      end
      LS_SYNC: begin // R20
        nxt.drive = meas_valid_i && !r.own_done ? 1'b0 : 1'b0;
        if (meas_valid_i) begin
          nxt.own_done = 1'b1;
          nxt.hold = 1'b1;
        end
        if (peer_cycle_end_i) begin
          nxt.own_done = 1'b0;
          nxt.hold = 1'b0;
          nxt.tx = 1'b1;
        end
        nxt.drive = r.own_done && !peer_cycle_end_i ? 1'b0 : !r.own_done;
      end
      LS_MUX: begin // R21
        nxt.drive = !r.own_done;
        if (meas_valid_i)
          nxt.own_done = 1'b1;
        if (peer_cycle_end_i) begin
          nxt.slot = (r.slot + 4'h1 >= r.count) ? 4'h0 : r.slot + 4'h1;
          nxt.own_done = 1'b0;
          nxt.tx = (((r.slot + 4'h1 >= r.count) ? 4'h0 : r.slot + 4'h1) == r.addr);
        end
      end
      default: begin
        nxt.own_done = 1'b0;
        nxt.hold = 1'b0;
        nxt.tx = meas_valid_i;
      end
    endcase
    nxt.led = (nxt.led_cnt != 32'h0);
    // analog code
    vmin = (r.amode == AM_I420) ? CODE_4MA : 16'h0000; // R7
    vmax = CODE_FULL; // R8
    span = 32'(r.a_end - r.a_start);
    off = 32'(echo_dist_i - r.a_start);
    scaled = (span == 32'h0) ? 32'h0 : off * 32'(vmax - vmin) / span; // R23
    if (meas_valid_i && !r.hold) begin // R23
      if (!valid_obj)
        nxt.code = r.beh[0] ? vmax : vmin; // R6 R12
      else if (echo_dist_i < r.a_start)
        nxt.code = r.beh[1] ? vmax : vmin; // R6
      else if (echo_dist_i > r.a_end)
        nxt.code = r.beh[2] ? vmax : vmin; // R6
      else if (r.rising)
        nxt.code = vmin + scaled[15:0]; // R4
      else
        nxt.code = vmax - scaled[15:0]; // R4
    end
    if (r.amode == AM_OFF)
      nxt.code = 16'h0000; // R3
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.a_start <= ARANGE_RST[15:0];
      r.a_end <= ARANGE_RST[31:16];
      r.sense_end <= SENSE_RST;
      r.bz1_off <= 1'b1;
      r.bz2_off <= 1'b1;
      r.adj_s <= ADJ_RST[15:0];
      r.adj_e <= ADJ_RST[31:16];
      r.lmode <= LS_IDLE;
      r.ln <= 3'h7;
      r.count <= 4'h1;
      r.teach_en <= 1'b0; // R19
    end else begin
      r <= nxt;
    end
  end

  assign dat_o = r.rdat;
  assign ack_o = r.ack;
  assign sync_teach_line_o = 1'b0;
  assign sync_teach_line_oe_o = r.drive;
  assign tx_start_o = r.tx;
  assign out_hold_o = r.hold;
  assign analog_code_o = r.code;
  assign led_green_o = r.led;
endmodule

// ==== dist_eval_checker.sv ====
// Purpose: port checks for dist_eval
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every dist_eval instance
`timescale 1ns/100ps
module dist_eval_checker #(
  parameter int HOLD_CYCLES = 100
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic sync_teach_line_i,
  input wire logic sync_teach_line_o,
  input wire logic sync_teach_line_oe_o,
  input wire logic tx_start_o,
  input wire logic out_hold_o,
  input wire logic [15:0] analog_code_o,
  input wire logic led_green_o
);
  int low_r;
  // consecutive cycles with the line grounded
  always_ff @(posedge clk_i) begin
    if (rst_i || sync_teach_line_i) low_r <= 0;
    else if (low_r < HOLD_CYCLES) low_r <= low_r + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ##1 ack_o ##1 !ack_o;
  endsequence
  chk_ack_answer: assert property (s_take |-> s_ans)
    else $error("ack not one cycle after request");
  chk_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  chk_line_low: assert property (sync_teach_line_o == 1'b0)
    else $error("shared line driven high");
  chk_reset_code: assert property (disable iff (1'b0)
    rst_i |=> analog_code_o == 16'h0000 && !led_green_o)
    else $error("code or led not cleared by reset");
  chk_reset_link: assert property (disable iff (1'b0)
    rst_i |=> !tx_start_o && !out_hold_o && !sync_teach_line_oe_o)
    else $error("link outputs not cleared by reset");
  chk_led_len: assert property ($rose(led_green_o) |-> led_green_o [*8])
    else $error("teach indication too short");
  chk_led_hold: assert property ($rose(led_green_o) |-> low_r >= HOLD_CYCLES)
    else $error("teach before line held long enough");
  chk_tx_pulse: assert property (tx_start_o |=> !tx_start_o)
    else $error("transmit start longer than one cycle");
endmodule
bind dist_eval dist_eval_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .ack_o(ack_o),
  .sync_teach_line_i(sync_teach_line_i),
  .sync_teach_line_o(sync_teach_line_o),
  .sync_teach_line_oe_o(sync_teach_line_oe_o),
  .tx_start_o(tx_start_o),
  .out_hold_o(out_hold_o),
  .analog_code_o(analog_code_o),
  .led_green_o(led_green_o)
);

// ==== dist_eval_pkg.sv ====
// Purpose: shared constants for the distance evaluation block
// Assumes: wishbone classic, 32-bit data, byte addresses
// Notes: distances in millimetres, analog code 16 bits full scale
package dist_eval_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int TEACH_HOLD_MS = 3000;
  localparam int TEACH_LED_MS = 500;
  localparam int HOLD_CYC = (CLK_HZ / 1000) * TEACH_HOLD_MS;
  localparam int LED_CYC = (CLK_HZ / 1000) * TEACH_LED_MS;
  localparam logic [15:0] SENSE_CEIL_MM = 16'h2774;
  localparam logic [15:0] CLOSE_RANGE_MM = 16'h00C8;
  localparam logic [15:0] CODE_FULL = 16'hFFFF;
  localparam logic [15:0] CODE_4MA = 16'h3333;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ARANGE = 8'h04;
  localparam logic [7:0] A_SENSE = 8'h08;
  localparam logic [7:0] A_BZ1 = 8'h0C;
  localparam logic [7:0] A_BZ2 = 8'h10;
  localparam logic [7:0] A_POT = 8'h14;
  localparam logic [7:0] A_ADJ = 8'h18;
  localparam logic [7:0] A_SYNC = 8'h1C;
  localparam logic [7:0] A_SP = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam logic [7:0] A_CLOSE = 8'h28;
  localparam logic [7:0] A_SVC = 8'h2C;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ARANGE_RST = 32'h07D0_00C8;
  localparam logic [15:0] SENSE_RST = 16'h1770;
  localparam logic [31:0] ADJ_RST = 32'h07D0_00C8;
  localparam logic [31:0] SVC_KEY = 32'h5A5A_A5A5;
  typedef enum logic [1:0] {
    AM_OFF = 2'h0,
    AM_I020 = 2'h1,
    AM_I420 = 2'h2,
    AM_V010 = 2'h3
  } amode_t;
  typedef enum logic [2:0] {
    LIM_NONE = 3'h0,
    LIM_SP11 = 3'h1,
    LIM_SP12 = 3'h2,
    LIM_SP21 = 3'h3,
    LIM_SP22 = 3'h4,
    LIM_ASTART = 3'h5,
    LIM_AEND = 3'h6
  } lim_t;
  typedef enum logic [3:0] {
    LS_IDLE = 4'b0001,
    LS_SYNC = 4'b0010,
    LS_MUX = 4'b0100,
    LS_TEACH = 4'b1000
  } lmode_t;
endpackage

// ==== peer_line.sv ====
// Purpose: shared line and peer sensors
// Assumes: pull-up on the line
// Notes: longest peer ends the common cycle
`timescale 1ns/100ps
module peer_line #(
  parameter int PERIOD = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dut_oe_i,
  input wire logic gnd_req_i,
  output logic line_o,
  output logic cycle_end_o
);
  int cnt;
  // open drain: any party pulls low, else pull-up
  assign line_o = !(dut_oe_i || gnd_req_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      cycle_end_o <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      cycle_end_o <= (cnt == PERIOD - 1);
    end
  end
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench for dist_eval
// Assumes: hold 100 and led 20 cycles, current variant
// Notes: distances random from a fixed seed
`timescale 1ns/100ps
module testbench;
  import dist_eval_pkg::*;
  `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
  localparam int HC = 100;
  localparam int LC = 20;
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic mv = 1'b0, ef = 1'b0, gnd = 1'b0;
  logic [7:0] adr_i = 8'h00, p1 = 8'h00, p2 = 8'h00;
  logic [31:0] dat_i = 32'h0, q;
  logic [15:0] ed = 16'h0;
  logic [3:0] sel_i = 4'h0;
  wire logic [31:0] dat_o;
  wire logic [15:0] code;
  wire logic ack_o, line, oe, lo, ce, tx, hold, led;
  int n_fail = 0, samples_checked = 0, seen, m, p, z;
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  dist_eval #(.HOLD_CYCLES(HC), .LED_CYCLES(LC)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .meas_valid_i(mv), .echo_found_i(ef), .echo_dist_i(ed),
    .pot1_pos_i(p1), .pot2_pos_i(p2), .sync_teach_line_i(line), .sync_teach_line_o(lo),
    .sync_teach_line_oe_o(oe), .peer_cycle_end_i(ce), .tx_start_o(tx), .out_hold_o(hold),
    .analog_code_o(code), .led_green_o(led));
  peer_line peer (.clk_i(clk_i), .rst_i(rst_i), .dut_oe_i(oe), .gnd_req_i(gnd),
    .line_o(line), .cycle_end_o(ce));
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= 4'hF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (ack_o !== 1'b1) begin
      n_fail++;
      results();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    `CHK("reg", e, q)
  endtask
  function automatic logic [15:0] lvl(input int md, input logic x);
    if (x) return CODE_FULL;
    return (md == 2) ? CODE_4MA : 16'h0000;
  endfunction
  task automatic meas(input logic f, input logic [15:0] d, input logic [15:0] e);
    int k;
    ef <= f;
    ed <= d;
    mv <= 1'b1;
    @(posedge clk_i);
    mv <= 1'b0;
    k = 0;
    @(posedge clk_i);
    `CHK("analog_code", e, code)
  endtask
  task automatic ground(input int n, output int s);
    int k;
    s = 0;
    gnd <= 1'b1;
    for (k = 0; k < n; k++) begin
      mv <= (k % 4 == 0);
      @(posedge clk_i);
      if (led === 1'b1) s++;
    end
    gnd <= 1'b0;
    mv <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  initial begin
    void'($urandom(32'h8B3D));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(A_CTRL, CTRL_RST);
    rc(A_ARANGE, ARANGE_RST);
    rc(A_ADJ, ADJ_RST);
    rc(A_SENSE, {16'h0, SENSE_RST});
    rc(8'h30, 32'h0);
    `CHK("code_rst", 16'h0000, code)
    wb(A_CLOSE, 1'b1, 32'h0000_FFFF);
    rc(A_CLOSE, {16'h0, CLOSE_RANGE_MM});
    wb(A_STAT, 1'b0, 32'h0);
    `CHK("reject", 1'b1, q[5])
    wb(A_STAT, 1'b1, 32'h0);
    wb(A_CTRL, 1'b1, 32'h0000_0003);
    rc(A_CTRL, 32'h0000_0000);
    wb(A_ARANGE, 1'b1, 32'h07D0_03E8);
    for (m = 1; m < 3; m++) begin
      for (p = 0; p < 8; p++) begin
        wb(A_CTRL, 1'b1, 32'(p * 16 + 8 + m));
        meas(1'b0, 16'h0, lvl(m, p[0]));
        meas(1'b1, 16'(300 + $urandom_range(699)), lvl(m, p[1]));
        meas(1'b1, 16'(2001 + $urandom_range(3998)), lvl(m, p[2]));
        meas(1'b1, 16'h1964, lvl(m, p[0]));
        meas(1'b1, 16'h0064, lvl(m, p[0]));
      end
      meas(1'b1, 16'h07D0, CODE_FULL);
      wb(A_CTRL, 1'b1, 32'(m));
      meas(1'b1, 16'h07D0, lvl(m, 1'b0));
      meas(1'b1, 16'h03E8, CODE_FULL);
      for (z = 0; z < 2; z++) begin
        wb(z ? A_BZ2 : A_BZ1, 1'b1, 32'h0640_0578);
        meas(1'b1, 16'h05DC, lvl(m, 1'b0));
        wb(z ? A_BZ2 : A_BZ1, 1'b1, 32'h8640_0578);
      end
    end
    wb(A_CTRL, 1'b1, 32'h0000_0070);
    meas(1'b1, 16'h0BB8, 16'h0000);
    wb(A_POT, 1'b1, 32'h0000_0035);
    p2 <= 8'hFF;
    repeat (4) @(posedge clk_i);
    rc(A_ARANGE, 32'h07D0_00C8);
    p1 <= 8'hFF;
    p2 <= 8'h00;
    repeat (4) @(posedge clk_i);
    rc(A_ARANGE, 32'h00C8_07D0);
    wb(A_POT, 1'b1, 32'h0000_0001);
    wb(A_SYNC, 1'b1, 32'h0000_0001);
    rc(A_STAT, {28'h0, LS_SYNC});
    ef <= 1'b1;
    ed <= 16'h05DC;
    ground(HC + 40, seen);
    `CHK("teach_off", 0, seen)
    wb(A_CTRL, 1'b1, 32'h0000_0080);
    rc(A_STAT, {28'h0, LS_TEACH});
    ef <= 1'b0;
    ground(HC + 40, seen);
    `CHK("teach_noobj", 0, seen)
    ef <= 1'b1;
    ground(2 * HC + 60, seen);
    `CHK("teach_rep", 1'b1, seen > LC)
    results();
  end
endmodule
